// [hw/sensor_powerup_config_sequencer.sv]
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_seq_defines.svh"

module sensor_powerup_config_sequencer #(
	parameter int WAIT_CYCLES = `RESET_WAIT_CYC,
	parameter int HOLD_CYCLES = `RESET_HOLD_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output var  logic [15:0] regRdData,
	output var  logic        sensorClkEn,
	output var  logic        sensorResetN,
	output var  logic        spiSclk,
	output var  logic        spiCsN,
	output var  logic        spiMosi
);

	localparam int CNT_W = $clog2(WAIT_CYCLES + HOLD_CYCLES + 2);

	sensor_seq_pkg::phase_t    phase_q;
	sensor_seq_pkg::spi_word_t curWord;
	sensor_seq_pkg::spi_word_t directWord_q;
	sensor_seq_pkg::spi_pins_t pins_q;
	logic [15:0]      ctrl_q;
	logic             clkEn_q;
	logic             rstN_q;
	logic [CNT_W-1:0] timer_q;
	logic [4:0]       step_q;
	logic [4:0]       bitCnt_q;
	logic [1:0]       div_q;
	logic [24:0]      shift_q;
	logic             spiBusy_q;
	logic             spiLoad;
	logic             spiDone;
	logic             error_q;
	logic             startReq;
	logic             directReq;
	logic [15:0]      rdData_q;

	// Upload list; option bits pick the per-variant values
	always_comb begin
		curWord = '0;
		case (step_q)
			5'd0:  curWord = '{`SREG_VARIANT,
				ctrl_q[`CTRL_COLOR_BIT] ? `VAL_COLOR : `VAL_MONO};
			5'd1:  curWord = '{`SREG_CLKGEN,   `VAL_CLK_CFG};
			5'd2:  curWord = '{`SREG_LOGIC_EN, `VAL_ONE};
			5'd3:  curWord = '{`SREG_GEN_BIAS, `VAL_GEN_BIAS};
			5'd4:  curWord = '{`SREG_FE_BIAS,  `VAL_FE_BIAS};
			5'd5:  curWord = '{`SREG_MUX_BIAS, `VAL_MUX_BIAS};
			5'd6:  curWord = '{`SREG_SER_BIAS, `VAL_SER_BIAS};
			5'd7:  curWord = '{`SREG_BLACKCAL, `VAL_BLACKCAL};
			5'd8:  curWord = '{`SREG_GAIN,
				ctrl_q[`CTRL_ZROT_BIT] ? `VAL_GAIN_ZROT : `VAL_GAIN_NROT};
			5'd9:  curWord = '{`SREG_DUMMYROW, `VAL_DUMMYROW};
			5'd10: curWord = '{`SREG_LATENCY,  `VAL_LATENCY};
			5'd11: curWord = '{`SREG_WORDCFG,
				ctrl_q[`CTRL_DEPTH8_BIT] ? `VAL_WORD8 : `VAL_WORD10};
			5'd12: curWord = '{`SREG_SEQ_A,    `VAL_SEQ_A};
			5'd13: curWord = '{`SREG_SEQ_B,    `VAL_SEQ_B};
			5'd14: curWord = '{`SREG_WIN_X,    `VAL_WIN_X};
			5'd15: curWord = '{`SREG_WIN_YS,
				ctrl_q[`CTRL_RES12K_BIT] ? `VAL_YS_12K : `VAL_YS_16K};
			5'd16: curWord = '{`SREG_WIN_YE,
				ctrl_q[`CTRL_RES12K_BIT] ? `VAL_YE_12K : `VAL_YE_16K};
			5'd17: curWord = '{`SREG_CLKGEN,   `VAL_CLK_ANALOG};
			5'd18: curWord = '{`SREG_BIAS_EN,  `VAL_ONE};
			5'd19: curWord = '{`SREG_COLMUX,   `VAL_COLMUX_ON};
			5'd20: curWord = '{`SREG_FRONTEND, `VAL_ONE};
			5'd21: curWord = '{`SREG_SERTX,    `VAL_SERTX_ON};
			5'd22: curWord = '{`SREG_SEQMODE,
				ctrl_q[`CTRL_ZROT_BIT] ? `VAL_SEQ_ZROT : `VAL_SEQ_NROT};
			default: curWord = '0;
		endcase
	end

	// Writes to the control and write-data registers request actions
	assign startReq  = regWrite && regAddr == `CSR_CTRL && regWrData[`CTRL_START_BIT];
	assign directReq = regWrite && regAddr == `CSR_WR_DATA;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= 16'h0000;
		end else if (regWrite && regAddr == `CSR_CTRL) begin
			ctrl_q <= {10'h000, regWrData[5:1], 1'b0};
		end
	end

	// Direct reconfiguration word, e.g. a mode change while running
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			directWord_q <= '0;
		end else if (regWrite && regAddr == `CSR_WR_ADDR) begin
			directWord_q.addr <= regWrData[8:0];
		end else if (directReq) begin
			directWord_q.data <= regWrData;
		end
	end

	// Clock enable and hard reset to the sensor
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clkEn_q <= 1'b0;
			rstN_q  <= 1'b0;
		end else if (regWrite && regAddr == `CSR_ENABLE) begin
			// Gates the clock, and a cleared bit also asserts sensor reset; its frequency must suit the depth bit
			clkEn_q <= regWrData[0];
			if (!regWrData[0]) begin
				rstN_q <= 1'b0;
			end
		end else if (phase_q == sensor_seq_pkg::PH_RESET && timer_q == '0) begin
			rstN_q <= 1'b1;
		end
	end

	// Main sequence: hold reset, wait, upload list, then running
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= sensor_seq_pkg::PH_IDLE;
			timer_q <= '0;
			step_q  <= 5'd0;
			error_q <= 1'b0;
		end else begin
			case (phase_q)
				sensor_seq_pkg::PH_IDLE: begin
					if (startReq) begin
						if (clkEn_q) begin
							phase_q <= sensor_seq_pkg::PH_RESET;
							timer_q <= CNT_W'(HOLD_CYCLES);
							error_q <= 1'b0;
						end else begin
							error_q <= 1'b1;                         // Clock must run first
						end
					end else if (directReq && rstN_q) begin
						phase_q <= sensor_seq_pkg::PH_DIRECT;
					end
				end
				sensor_seq_pkg::PH_RESET: begin
					if (timer_q == '0) begin
						phase_q <= sensor_seq_pkg::PH_WAIT;
						timer_q <= CNT_W'(WAIT_CYCLES);
					end else begin
						timer_q <= timer_q - 1'b1;
					end
				end
				sensor_seq_pkg::PH_WAIT: begin
					if (timer_q == '0) begin
						phase_q <= sensor_seq_pkg::PH_UPLOAD;
						step_q  <= 5'd0;
					end else begin
						timer_q <= timer_q - 1'b1;
					end
				end
				sensor_seq_pkg::PH_UPLOAD: begin
					phase_q <= sensor_seq_pkg::PH_SPI;
				end
				sensor_seq_pkg::PH_SPI: begin
					if (spiDone) begin
						if (step_q == `STEP_LAST) begin
							phase_q <= sensor_seq_pkg::PH_RUNNING;
						end else begin
							step_q  <= step_q + 5'd1;
							phase_q <= sensor_seq_pkg::PH_UPLOAD;
						end
					end
				end
				sensor_seq_pkg::PH_RUNNING: begin
					if (!clkEn_q) begin
						phase_q <= sensor_seq_pkg::PH_IDLE;
					end else if (directReq) begin
						phase_q <= sensor_seq_pkg::PH_DIRECT;
					end
				end
				sensor_seq_pkg::PH_DIRECT: begin
					if (spiDone) begin
						phase_q <= rstN_q && step_q == `STEP_LAST ?
							sensor_seq_pkg::PH_RUNNING : sensor_seq_pkg::PH_IDLE;
					end
				end
				default: phase_q <= sensor_seq_pkg::PH_IDLE;
			endcase
		end
	end

	// Load the shifter once per word; one write in flight at a time
	assign spiLoad = (phase_q == sensor_seq_pkg::PH_UPLOAD) ||
		(directReq && !spiBusy_q && phase_q != sensor_seq_pkg::PH_DIRECT &&
		(phase_q == sensor_seq_pkg::PH_RUNNING ||
		(phase_q == sensor_seq_pkg::PH_IDLE && rstN_q && !startReq)));
	assign spiDone = spiBusy_q && bitCnt_q == 5'd0 && div_q == 2'd3 && pins_q.sclk;

	// Write frame: one write flag, 9 address bits, 16 data bits, MSB first
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			spiBusy_q <= 1'b0;
			shift_q   <= '0;
			bitCnt_q  <= 5'd0;
			div_q     <= 2'd0;
			pins_q    <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};
		end else if (spiLoad) begin
			spiBusy_q   <= 1'b1;
			bitCnt_q    <= 5'd25;
			div_q       <= 2'd0;
			pins_q.csN  <= 1'b0;
			pins_q.mosi <= 1'b1;
			shift_q     <= phase_q == sensor_seq_pkg::PH_UPLOAD ?
				{curWord.addr, curWord.data} : {directWord_q.addr, regWrData};
		end else if (spiBusy_q) begin
			div_q <= div_q + 2'd1;
			if (div_q == 2'd1) begin
				pins_q.sclk <= 1'b1;
			end else if (div_q == 2'd3) begin
				pins_q.sclk <= 1'b0;
				if (bitCnt_q == 5'd0) begin
					spiBusy_q  <= 1'b0;
					pins_q.csN <= 1'b1;
				end else begin
					bitCnt_q    <= bitCnt_q - 5'd1;
					pins_q.mosi <= shift_q[24];
					shift_q     <= {shift_q[23:0], 1'b0};
				end
			end
		end
	end

	// Read port: data valid in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdData_q <= 16'h0000;
		end else if (regRead) begin
			case (regAddr)
				`CSR_CTRL:    rdData_q <= ctrl_q;
				`CSR_STATUS:  rdData_q <= {6'h00, error_q, spiBusy_q, step_q, phase_q};
				`CSR_ENABLE:  rdData_q <= {14'h0000, rstN_q, clkEn_q};
				`CSR_WR_ADDR: rdData_q <= {7'h00, directWord_q.addr};
				`CSR_WR_DATA: rdData_q <= directWord_q.data;
				default:      rdData_q <= 16'h0000;
			endcase
		end else begin
			rdData_q <= 16'h0000;
		end
	end

	assign regRdData    = rdData_q;
	assign sensorClkEn  = clkEn_q;
	assign sensorResetN = rstN_q;
	assign spiSclk      = pins_q.sclk;
	assign spiCsN       = pins_q.csN;
	assign spiMosi      = pins_q.mosi;

endmodule
`default_nettype wire

// [hw/sensor_seq_defines.svh]
`ifndef SENSOR_SEQ_DEFINES_SVH
`define SENSOR_SEQ_DEFINES_SVH

// Host command register offsets
`define CSR_CTRL           4'h0
`define CSR_STATUS         4'h1
`define CSR_ENABLE         4'h2
`define CSR_WR_ADDR        4'h3
`define CSR_WR_DATA        4'h4

// Control register fields
`define CTRL_START_BIT     0
`define CTRL_COLOR_BIT     1
`define CTRL_ZROT_BIT      2
`define CTRL_DEPTH8_BIT    3
`define CTRL_RES12K_BIT    4
`define CTRL_DIRECT_BIT    5

// Sensor register addresses
`define SREG_VARIANT       9'h002
`define SREG_CLKGEN        9'h020
`define SREG_LOGIC_EN      9'h022
`define SREG_COLMUX        9'h028
`define SREG_FRONTEND      9'h030
`define SREG_BIAS_EN       9'h040
`define SREG_GEN_BIAS      9'h041
`define SREG_FE_BIAS       9'h042
`define SREG_MUX_BIAS      9'h043
`define SREG_SER_BIAS      9'h044
`define SREG_SERTX         9'h070
`define SREG_BLACKCAL      9'h080
`define SREG_WORDCFG       9'h081
`define SREG_SEQMODE       9'h0c0
`define SREG_GAIN          9'h0cc
`define SREG_DUMMYROW      9'h0e0
`define SREG_LATENCY       9'h0e1
`define SREG_WIN_X         9'h100
`define SREG_WIN_YS        9'h101
`define SREG_WIN_YE        9'h102
`define SREG_SEQ_A         9'h1bf
`define SREG_SEQ_B         9'h1c0

// Upload data values
`define VAL_MONO           16'h0000
`define VAL_COLOR          16'h0001
`define VAL_CLK_CFG        16'h2002
`define VAL_ONE            16'h0001
`define VAL_GEN_BIAS       16'h008b
`define VAL_FE_BIAS        16'h53c8
`define VAL_MUX_BIAS       16'h8848
`define VAL_SER_BIAS       16'h0086
`define VAL_BLACKCAL       16'h4520
`define VAL_GAIN_NROT      16'h09e5
`define VAL_GAIN_ZROT      16'h09e6
`define VAL_DUMMYROW       16'h3e04
`define VAL_LATENCY        16'h6733
`define VAL_WORD10         16'h0000
`define VAL_WORD8          16'h2000
`define VAL_SEQ_A          16'h0bf1
`define VAL_SEQ_B          16'h0bc3
`define VAL_WIN_X          16'h4708
`define VAL_YS_16K         16'h0200
`define VAL_YS_12K         16'h0400
`define VAL_YE_16K         16'h11ff
`define VAL_YE_12K         16'h0fff
`define VAL_CLK_ANALOG     16'h2003
`define VAL_COLMUX_ON      16'h0003
`define VAL_SERTX_ON       16'h0007
`define VAL_SEQ_NROT       16'h0001
`define VAL_SEQ_ZROT       16'h000d

// Timing
`define CLK_MHZ            200
`define RESET_WAIT_US      10
`define RESET_WAIT_CYC     (`RESET_WAIT_US * `CLK_MHZ)
`define RESET_HOLD_CYC     16
`define SPI_DIV            4
`define STEP_LAST          5'd22

`endif

// [hw/sensor_seq_pkg.sv]
package sensor_seq_pkg;

	// Host sequencer phases
	typedef enum logic [2:0] {
		PH_IDLE    = 3'b000,
		PH_RESET   = 3'b001,
		PH_WAIT    = 3'b010,
		PH_UPLOAD  = 3'b011,
		PH_SPI     = 3'b100,
		PH_RUNNING = 3'b101,
		PH_DIRECT  = 3'b110
	} phase_t;

	// One sensor register write
	typedef struct packed {
		logic [8:0]  addr;
		logic [15:0] data;
	} spi_word_t;

	// SPI pins towards the sensor
	typedef struct packed {
		logic sclk;
		logic csN;
		logic mosi;
	} spi_pins_t;

endpackage

// [testbench/sensor_seq_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sensor_seq_chk #(
	parameter int WAIT_CYCLES = 2000
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic sensorClkEn,
	input wire logic sensorResetN,
	input wire logic spiSclk,
	input wire logic spiCsN,
	input wire logic spiMosi
);
	int   waitCnt;
	int   bitCnt;
	logic sclkQ;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Cycles since sensor reset release, saturating so it cannot wrap
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) waitCnt <= 0;
		else if (!sensorResetN) waitCnt <= 0;
		else if (waitCnt < WAIT_CYCLES) waitCnt <= waitCnt + 1;
	end
	// Rising sclk edges inside one frame
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bitCnt <= 0;
			sclkQ <= 1'b0;
		end else begin
			sclkQ <= spiSclk;
			bitCnt <= spiCsN ? 0 : bitCnt + int'(spiSclk & ~sclkQ);
		end
	end
	a_reset_after_clk: assert property ($rose(sensorResetN) |-> sensorClkEn && $past(sensorClkEn))
		else $error("reset released without clock");
	a_wait_after_reset: assert property ($fell(spiCsN) |-> waitCnt >= WAIT_CYCLES)
		else $error("frame too soon after reset");
	a_no_spi_reset: assert property (!sensorResetN |-> spiCsN)
		else $error("frame during sensor reset");
	a_frame_bits: assert property ($rose(spiCsN) |-> bitCnt == 26)
		else $error("frame length wrong");
	a_sclk_idle_low: assert property (spiCsN |-> !spiSclk)
		else $error("sclk moves outside frame");
	a_write_flag: assert property ($fell(spiCsN) |-> spiMosi)
		else $error("first bit not write");
	a_mosi_stable: assert property ($rose(spiSclk) |-> $stable(spiMosi))
		else $error("mosi moved at sample edge");
	a_frame_gap: assert property ($fell(spiCsN) |-> !spiSclk && bitCnt == 0)
		else $error("frames overlap");
endmodule
bind sensor_powerup_config_sequencer sensor_seq_chk #(.WAIT_CYCLES(WAIT_CYCLES)) i_chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .sensorClkEn(sensorClkEn),
	.sensorResetN(sensorResetN), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi));
`default_nettype wire

// [testbench/sensor_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	input wire logic resetN
);
	logic [25:0] sh;
	logic [24:0] wlog [32];
	logic [15:0] regs [512];
	logic [1:0]  st;
	int          cnt;
	// Shift on rising sclk; no read-back line, so nothing is driven back
	always @(posedge sclk) if (!csN) sh <= {sh[24:0], mosi};
	// Apply a frame when chip select rises; state moves only by writes or sensor reset
	always @(posedge csN or negedge resetN) begin
		if (!resetN) begin
			st <= 2'd0;
			cnt <= 0;
		end else if (sh[25]) begin
			wlog[cnt] <= sh[24:0];
			cnt <= cnt + 1;
			if (st != 2'd0 || sh[24:16] < 9'h028) regs[sh[24:16]] <= sh[15:0];
			if (st == 2'd0 && sh[24:0] == 25'h0220001) st <= 2'd1;
			if (st == 2'd1 && sh[24:0] == 25'h0700007) st <= 2'd2;
			if (st[1] && sh[24:16] == 9'h0c0) st <= {1'b1, sh[0]};
		end
	end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        ref_clk = 1'b0;
	logic        reset_n;
	logic [3:0]  regAddr;
	logic [15:0] regWrData;
	logic        regWrite;
	logic        regRead;
	logic [15:0] regRdData;
	logic        sensorClkEn;
	logic        sensorResetN;
	logic        spiSclk;
	logic        spiCsN;
	logic        spiMosi;
	logic [24:0] t [23];
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cyc = 0;
	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;
	// Short waits keep the run small; checks follow the parameters
	sensor_powerup_config_sequencer #(
		.WAIT_CYCLES(20),
		.HOLD_CYCLES(2)
	) i_sensor_powerup_config_sequencer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdData(regRdData),
		.sensorClkEn(sensorClkEn),
		.sensorResetN(sensorResetN),
		.spiSclk(spiSclk),
		.spiCsN(spiCsN),
		.spiMosi(spiMosi)
	);
	sensor_model i_sensor_model (.sclk(spiSclk), .csN(spiCsN), .mosi(spiMosi), .resetN(sensorResetN));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(logic [24:0] got, logic [24:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rchk(logic [3:0] a, logic [15:0] exp, logic [15:0] msk);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 cmp(25'(regRdData & msk), 25'(exp));
	endtask
	task automatic wt(int n);
		for (int k = 0; k < 4000 && i_sensor_model.cnt < n; k++) @(posedge ref_clk);
	endtask
	// Full bring-up in one variant; m holds start, color, zero overhead, 8-bit, 12K
	task automatic run(logic [4:0] m);
		t = '{25'h0020000 | m[1], 25'h0202002, 25'h0220001,
			25'h041008b, 25'h04253c8, 25'h0438848, 25'h0440086, 25'h0804520,
			m[2] ? 25'h0cc09e6 : 25'h0cc09e5, 25'h0e03e04, 25'h0e16733,
			m[3] ? 25'h0812000 : 25'h0810000, 25'h1bf0bf1, 25'h1c00bc3, 25'h1004708,
			m[4] ? 25'h1010400 : 25'h1010200, m[4] ? 25'h1020fff : 25'h10211ff,
			25'h0202003, 25'h0400001, 25'h0280003, 25'h0300001, 25'h0700007,
			m[2] ? 25'h0c0000d : 25'h0c00001};
		wr(4'h2, 16'h0001);
		wr(4'h0, {11'h000, m});
		wt(23);
		for (int i = 0; i < 23; i++) cmp(i_sensor_model.wlog[i], t[i]);
		rchk(4'h1, 16'h0005, 16'h0307);
		rchk(4'h2, 16'h0002, 16'h0002);
		cmp(25'(i_sensor_model.st), 25'h3);
	endtask
	// Main sequence
	initial begin
		reset_n = 1'b0;
		regAddr = 4'h0;
		regWrData = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		rchk(4'h1, 16'h0000, 16'hffff);
		rchk(4'h2, 16'h0000, 16'h0002);
		rchk(4'h7, 16'h0000, 16'hffff);
		$display("test reset values done");
		wr(4'h0, 16'h0001);
		rchk(4'h1, 16'h0200, 16'h0207);
		cmp(25'(sensorResetN), 25'h0);
		$display("test refused start done");
		run(5'h01);
		$display("test mono normal done");
		wr(4'h3, 16'h0081);
		wr(4'h4, 16'h2000);
		wt(24);
		cmp(i_sensor_model.wlog[23], 25'h0812000);
		cmp(25'(i_sensor_model.st), 25'h3);
		$display("test direct write done");
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		#1 cmp(25'(i_sensor_model.st), 25'h0);
		run(5'h1f);
		$display("test color zero overhead done");
		print_verdict();
	end
	// Hang guard, well above two uploads
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
endmodule
`default_nettype wire
